// File: core/trc_map.vh
// Register offsets, field positions and reset values for the timer run and wrap control.
`ifndef TRC_MAP_VH
`define TRC_MAP_VH
`define TRC_BASIC_CTRL_ADDR 8'h88
`define TRC_EXT_CTRL_ADDR 8'hc8
`define TRC_BASIC_CTRL_RESET 8'h00
`define TRC_EXT_CTRL_RESET 8'h00
`define TRC_B_T1_WRAP 7
`define TRC_B_T1_RUN 6
`define TRC_B_T0_WRAP 5
`define TRC_B_T0_RUN 4
`define TRC_E_WRAP 7
`define TRC_E_PIN_EVT 6
`define TRC_E_PIN_EN 3
`define TRC_E_RUN 2
`define TRC_E_SRC_SEL 1
`define TRC_E_CAP_SEL 0
`define TRC_E_RW_MASK 8'hcf
`define TRC_ALL_ONES 16'hffff
`define TRC_ZERO 16'h0000
`endif

// File: core/trc_ext_timer.v
// One extended 16-bit timer with auto-reload, capture and external pin events.
`timescale 1ns/100ps
`include "trc_map.vh"
module trc_ext_timer
(
  // Clock and reset
  input wire clock_i,
  input wire rstn_i,
  // Control fields
  input wire run_i,
  input wire src_sel_i,
  input wire cap_sel_i,
  input wire pin_en_i,
  input wire down_i,
  // Synchronised pins
  input wire count_pin_i,
  input wire trigger_pin_i,
  // Reload register, written by software
  input wire reload_wr_i,
  input wire [15:0] reload_data_i,
  // Results
  output reg wrap_o,
  output reg pin_event_o,
  output reg [15:0] count_o,
  output reg [15:0] capture_o
);
  reg count_pin_q;
  reg trig_pin_q;
  reg [15:0] reload_q;
  wire count_fall;
  wire trig_fall;
  wire tick;
  wire dir_down;
  assign count_fall = count_pin_q & ~count_pin_i;
  assign trig_fall = trig_pin_q & ~trigger_pin_i;
  assign tick = run_i & (src_sel_i ? count_fall : 1'b1);
  // Down-counting only exists with the pin enabled, where the pin level steers direction.
  assign dir_down = down_i;
  always @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      count_pin_q <= 1'b1;
      trig_pin_q <= 1'b1;
      reload_q <= `TRC_ZERO;
      count_o <= `TRC_ZERO;
      capture_o <= `TRC_ZERO;
      wrap_o <= 1'b0;
      pin_event_o <= 1'b0;
    end
    else
    begin
      count_pin_q <= count_pin_i;
      trig_pin_q <= trigger_pin_i;
      wrap_o <= 1'b0;
      pin_event_o <= 1'b0;
      if (reload_wr_i)
        reload_q <= reload_data_i;
      if (tick)
      begin
        if (!dir_down)
        begin
          if (count_o == `TRC_ALL_ONES)
          begin
            wrap_o <= 1'b1;
            count_o <= cap_sel_i ? `TRC_ZERO : reload_q;
          end
          else
            count_o <= count_o + 16'h0001;
        end
        else if (!cap_sel_i && count_o == reload_q)
        begin
          wrap_o <= 1'b1;
          count_o <= `TRC_ALL_ONES;
        end
        else if (cap_sel_i && count_o == `TRC_ZERO)
        begin
          wrap_o <= 1'b1;
          count_o <= `TRC_ALL_ONES;
        end
        else
          count_o <= count_o - 16'h0001;
      end
      if (pin_en_i && trig_fall)
      begin
        if (cap_sel_i)
        begin
          capture_o <= count_o;
          pin_event_o <= 1'b1;
        end
        else if (!dir_down)
        begin
          count_o <= reload_q;
          pin_event_o <= 1'b1;
        end
      end
    end
  end
endmodule // trc_ext_timer

// File: core/trc_timer_ctrl.v
// Control and status registers for two basic timers and three extended timers.
`timescale 1ns/100ps
`include "trc_map.vh"
module trc_timer_ctrl
#(
  parameter NEXT = 3
)
(
  // Clock and reset
  input wire clock_i,
  input wire rstn_i,
  // Register port; page selects which extended timer is seen at its offset
  input wire [7:0] reg_addr_i,
  input wire [1:0] reg_page_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  // Reload pair write, one strobe per extended timer
  input wire [NEXT-1:0] reload_wr_i,
  input wire [15:0] reload_data_i,
  // Basic timer rollover events from the counters
  input wire timer_zero_rollover_i,
  input wire timer_one_rollover_i,
  // Interrupt entry acknowledges
  input wire timer_zero_isr_entry_i,
  input wire timer_one_isr_entry_i,
  // Extended timer pins and controls
  input wire [NEXT-1:0] ext_count_pin_i,
  input wire [NEXT-1:0] ext_timer_trigger_pin_i,
  input wire [NEXT-1:0] ext_timer_down_i,
  input wire [NEXT-1:0] ext_timer_irq_enable_i,
  // Outputs
  output reg timer_zero_run_o,
  output reg timer_one_run_o,
  output reg [NEXT-1:0] ext_timer_irq_o,
  output reg [16*NEXT-1:0] ext_count_o,
  output reg [16*NEXT-1:0] ext_capture_o
);
  reg [7:0] basic_ctrl_q;
  reg [7:0] ext_ctrl_q [0:NEXT-1];
  reg [NEXT-1:0] cnt_s1_q;
  reg [NEXT-1:0] cnt_s2_q;
  reg [NEXT-1:0] trg_s1_q;
  reg [NEXT-1:0] trg_s2_q;
  wire [NEXT-1:0] wrap_ev;
  wire [NEXT-1:0] pin_ev;
  wire [16*NEXT-1:0] cnt_w;
  wire [16*NEXT-1:0] cap_w;
  wire basic_wr;
  wire basic_rd;
  wire ext_wr;
  wire ext_rd;
  reg [7:0] rdata_d;
  integer i;
  integer j;
  integer m;

  function sel_hit;
    input [7:0] a;
    input [7:0] off;
    begin
      sel_hit = (a == off);
    end
  endfunction

  // The extended timers share one offset, so the page picks which of them an
  // access lands on.
  function page_hit;
    input [1:0] pg;
    input integer idx;
    begin
      page_hit = (pg == idx[1:0]);
    end
  endfunction

  // Each offset is decoded separately for the write path and for the read path.
  assign basic_wr = reg_wr_i & sel_hit(reg_addr_i, `TRC_BASIC_CTRL_ADDR);
  assign basic_rd = reg_rd_i & sel_hit(reg_addr_i, `TRC_BASIC_CTRL_ADDR);
  assign ext_wr = reg_wr_i & sel_hit(reg_addr_i, `TRC_EXT_CTRL_ADDR);
  assign ext_rd = reg_rd_i & sel_hit(reg_addr_i, `TRC_EXT_CTRL_ADDR);

  genvar g;
  generate
    for (g = 0; g < NEXT; g = g + 1)
    begin : g_ext
      trc_ext_timer u_tmr
      (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .run_i(ext_ctrl_q[g][`TRC_E_RUN]),
        .src_sel_i(ext_ctrl_q[g][`TRC_E_SRC_SEL]),
        .cap_sel_i(ext_ctrl_q[g][`TRC_E_CAP_SEL]),
        .pin_en_i(ext_ctrl_q[g][`TRC_E_PIN_EN]),
        .down_i(ext_timer_down_i[g] & ext_ctrl_q[g][`TRC_E_PIN_EN]),
        .count_pin_i(cnt_s2_q[g]),
        .trigger_pin_i(trg_s2_q[g]),
        .reload_wr_i(reload_wr_i[g]),
        .reload_data_i(reload_data_i),
        .wrap_o(wrap_ev[g]),
        .pin_event_o(pin_ev[g]),
        .count_o(cnt_w[16*g +: 16]),
        .capture_o(cap_w[16*g +: 16])
      );
    end
  endgenerate

  // Pins are synchronised here; the second stage alone feeds the timers.
  // They reset high, the idle level of the pins, so reset release makes no false fall.
  always @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cnt_s1_q <= {NEXT{1'b1}};
      cnt_s2_q <= {NEXT{1'b1}};
      trg_s1_q <= {NEXT{1'b1}};
      trg_s2_q <= {NEXT{1'b1}};
    end
    else
    begin
      cnt_s1_q <= ext_count_pin_i;
      cnt_s2_q <= cnt_s1_q;
      trg_s1_q <= ext_timer_trigger_pin_i;
      trg_s2_q <= trg_s1_q;
    end
  end

  // Basic timer control. A hardware set in the same cycle as a clear wins, so
  // no rollover of a running timer is lost; a rollover while stopped is ignored.
  always @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      basic_ctrl_q <= `TRC_BASIC_CTRL_RESET;
    else
    begin
      if (basic_wr)
        basic_ctrl_q <= reg_wdata_i;
      if (timer_zero_isr_entry_i)
        basic_ctrl_q[`TRC_B_T0_WRAP] <= 1'b0;
      if (timer_one_isr_entry_i)
        basic_ctrl_q[`TRC_B_T1_WRAP] <= 1'b0;
      if (timer_zero_rollover_i && basic_ctrl_q[`TRC_B_T0_RUN])
        basic_ctrl_q[`TRC_B_T0_WRAP] <= 1'b1;
      if (timer_one_rollover_i && basic_ctrl_q[`TRC_B_T1_RUN])
        basic_ctrl_q[`TRC_B_T1_WRAP] <= 1'b1;
    end
  end

  // Extended timer control, one register per page; a set again beats a clear.
  always @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      for (i = 0; i < NEXT; i = i + 1)
        ext_ctrl_q[i] <= `TRC_EXT_CTRL_RESET;
    end
    else
    begin
      for (i = 0; i < NEXT; i = i + 1)
      begin
        // Flags stay set through interrupt entry; only a write clears them.
        if (ext_wr && page_hit(reg_page_i, i))
          ext_ctrl_q[i] <= reg_wdata_i & `TRC_E_RW_MASK;
        if (wrap_ev[i])
          ext_ctrl_q[i][`TRC_E_WRAP] <= 1'b1;
        if (pin_ev[i])
          ext_ctrl_q[i][`TRC_E_PIN_EVT] <= 1'b1;
      end
    end
  end

  // Read data is chosen here and registered below; an unmatched read returns zero.
  always @*
  begin
    rdata_d = 8'h00;
    if (basic_rd)
      rdata_d = basic_ctrl_q;
    else if (ext_rd)
    begin
      for (m = 0; m < NEXT; m = m + 1)
        if (page_hit(reg_page_i, m))
          rdata_d = ext_ctrl_q[m];
    end
  end

  // Every output leaves through a flip-flop, so the run bits reach the basic
  // counters one cycle after the register changes.
  always @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      reg_rdata_o <= 8'h00;
      timer_zero_run_o <= 1'b0;
      timer_one_run_o <= 1'b0;
      ext_timer_irq_o <= {NEXT{1'b0}};
      ext_count_o <= {16*NEXT{1'b0}};
      ext_capture_o <= {16*NEXT{1'b0}};
    end
    else
    begin
      timer_zero_run_o <= basic_ctrl_q[`TRC_B_T0_RUN];
      timer_one_run_o <= basic_ctrl_q[`TRC_B_T1_RUN];
      ext_count_o <= cnt_w;
      ext_capture_o <= cap_w;
      for (j = 0; j < NEXT; j = j + 1)
        ext_timer_irq_o[j] <= ext_timer_irq_enable_i[j] &
          (ext_ctrl_q[j][`TRC_E_WRAP] | ext_ctrl_q[j][`TRC_E_PIN_EVT]);
      reg_rdata_o <= rdata_d;
    end
  end
endmodule // trc_timer_ctrl

// File: verif/trc_ctrl_asserts.sv
// Port checker for the timer run and wrap control.
`timescale 1ns/100ps
module trc_ctrl_asserts
#(
  parameter NEXT = 3
)
(
  // Clock and reset
  input wire clock_i,
  input wire rstn_i,
  // Register port
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_wdata_i,
  input wire [7:0] reg_rdata_o,
  // Timer side
  input wire [NEXT-1:0] ext_timer_irq_enable_i,
  input wire timer_zero_run_o,
  input wire timer_one_run_o,
  input wire [NEXT-1:0] ext_timer_irq_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);
  wire basic_wr = reg_wr_i && reg_addr_i == 8'h88;
  wire ext_wr = reg_wr_i && reg_addr_i == 8'hc8;
  a_zero_run_start: assert property (
    basic_wr && reg_wdata_i[4] |-> ##2 timer_zero_run_o)
    else $error("timer zero run did not follow its write");
  a_one_run_stop: assert property (
    basic_wr && !reg_wdata_i[6] |-> ##2 !timer_one_run_o)
    else $error("timer one run did not stop after its write");
  a_run_steady: assert property (
    !basic_wr && !$past(basic_wr) |=> $stable(timer_zero_run_o))
    else $error("timer zero run moved without a write");
  a_read_run_match: assert property (
    $past(reg_rd_i && reg_addr_i == 8'h88)
    |-> reg_rdata_o[4] == timer_zero_run_o && reg_rdata_o[6] == timer_one_run_o)
    else $error("basic read data disagrees with run outputs");
  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  a_reserved_zero: assert property ($past(reg_rd_i && reg_addr_i == 8'hc8)
    |-> reg_rdata_o[5:4] == 2'b00)
    else $error("reserved extended bits read nonzero");
  a_irq_needs_enable: assert property (
    (ext_timer_irq_o & ~$past(ext_timer_irq_enable_i)) == 0)
    else $error("interrupt raised while disabled");
  a_irq_flag_holds: assert property (
    ext_timer_irq_o[0] && ext_timer_irq_enable_i[0] && !ext_wr
    && !$past(ext_wr) |=> ext_timer_irq_o[0])
    else $error("wrap interrupt dropped without a write");
  c_irq: cover property (ext_timer_irq_o[0]);
  c_run: cover property (timer_zero_run_o && timer_one_run_o);
  c_ext_read: cover property ($past(reg_rd_i && reg_addr_i == 8'hc8));
endmodule // trc_ctrl_asserts

bind trc_timer_ctrl trc_ctrl_asserts #(.NEXT(NEXT)) u_chk (.clock_i(clock_i), .rstn_i(rstn_i),
  .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .ext_timer_irq_enable_i(ext_timer_irq_enable_i),
  .timer_zero_run_o(timer_zero_run_o), .timer_one_run_o(timer_one_run_o),
  .ext_timer_irq_o(ext_timer_irq_o));

// File: verif/tb.sv
// Directed bench for the timer run and wrap control.
`timescale 1ns/100ps
module tb;
  reg clock_i = 1'b0;
  reg rstn_i = 1'b0;
  reg [7:0] a = 8'h00;
  reg [7:0] wd = 8'h00;
  reg [1:0] p = 2'h0;
  reg we = 1'b0, re = 1'b0, ro0 = 1'b0, ro1 = 1'b0, isr0 = 1'b0, isr1 = 1'b0;
  reg [2:0] cp = 3'h7, tp = 3'h7, dn = 3'h0, ie = 3'h1, rlw = 3'h0;
  reg [15:0] rld = 16'h0000;
  reg [7:0] d;
  wire [7:0] rdat;
  wire run0, run1;
  wire [2:0] irq;
  wire [47:0] cnt, cap;
  integer n_errors = 0, samples_checked = 0, i;
  always #25 clock_i = ~clock_i;
  trc_timer_ctrl #(.NEXT(3)) u_dut (.clock_i(clock_i), .rstn_i(rstn_i), .reg_addr_i(a),
    .reg_page_i(p), .reg_wr_i(we), .reg_rd_i(re), .reg_wdata_i(wd), .reg_rdata_o(rdat),
    .reload_wr_i(rlw), .reload_data_i(rld), .timer_zero_rollover_i(ro0),
    .timer_one_rollover_i(ro1), .timer_zero_isr_entry_i(isr0), .timer_one_isr_entry_i(isr1),
    .ext_count_pin_i(cp), .ext_timer_trigger_pin_i(tp), .ext_timer_down_i(dn),
    .ext_timer_irq_enable_i(ie), .timer_zero_run_o(run0), .timer_one_run_o(run1),
    .ext_timer_irq_o(irq), .ext_count_o(cnt), .ext_capture_o(cap));
  task chk(input string nm, input [15:0] e, input [15:0] g);
    samples_checked = samples_checked + 1;
    if (g !== e)
    begin
      $display("unexpected %0s expected %h seen %h", nm, e, g);
      n_errors = n_errors + 1;
    end
  endtask
  task wr(input [7:0] ad, input [1:0] pg, input [7:0] v);
    @(negedge clock_i);
    a = ad;
    p = pg;
    wd = v;
    we = 1'b1;
    @(negedge clock_i) we = 1'b0;
  endtask
  // Read data stands for one cycle only, so it is taken at the first falling edge.
  task rd(input [7:0] ad, input [1:0] pg, output [7:0] v);
    @(negedge clock_i);
    a = ad;
    p = pg;
    re = 1'b1;
    @(negedge clock_i) v = rdat;
    re = 1'b0;
  endtask
  task wt(input integer b);
    d = 8'h00;
    for (i = 0; i < 400 && d[b] !== 1'b1; i = i + 1)
      rd(8'hc8, 2'h0, d);
    chk("extended flag", 16'h0001, {15'h0000, d[b]});
    if (d[b] !== 1'b1)
      finish_test;
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(negedge clock_i);
    rstn_i = 1'b1;
    rd(8'h88, 2'h0, d);
    chk("basic reset", 16'h0000, d);
    rd(8'hc8, 2'h0, d);
    chk("extended reset", 16'h0000, d);
    $display("test reset values done");
    wr(8'h88, 2'h0, 8'h10);
    repeat (2) @(negedge clock_i);
    chk("timer zero run", 16'h0001, run0);
    @(negedge clock_i) ro0 = 1'b1;
    @(negedge clock_i) ro0 = 1'b0;
    rd(8'h88, 2'h0, d);
    chk("zero wrap set", 16'h0030, d);
    @(negedge clock_i) isr0 = 1'b1;
    @(negedge clock_i) isr0 = 1'b0;
    @(negedge clock_i) ro1 = 1'b1;
    @(negedge clock_i) ro1 = 1'b0;
    rd(8'h88, 2'h0, d);
    chk("isr clear, stopped one", 16'h0010, d);
    @(negedge clock_i) ro0 = 1'b1;
    @(negedge clock_i) ro0 = 1'b0;
    wr(8'h88, 2'h0, 8'h50);
    wr(8'h89, 2'h0, 8'hff);
    rd(8'h88, 2'h0, d);
    chk("zero written clear", 16'h0050, d);
    chk("timer one run", 16'h0001, run1);
    @(negedge clock_i) ro1 = 1'b1;
    @(negedge clock_i) ro1 = 1'b0;
    rd(8'h88, 2'h0, d);
    chk("one wrap set", 16'h00d0, d);
    @(negedge clock_i) isr1 = 1'b1;
    @(negedge clock_i) isr1 = 1'b0;
    rd(8'h88, 2'h0, d);
    chk("one isr clear", 16'h0050, d);
    $display("test basic timers done");
    wr(8'hc8, 2'h1, 8'hfb);
    rd(8'hc8, 2'h1, d);
    chk("page one control", 16'h00cb, d);
    rd(8'hc8, 2'h2, d);
    chk("page two control", 16'h0000, d);
    wr(8'hc8, 2'h1, 8'h00);
    $display("test register pages done");
    dn = 3'h1;
    wr(8'hc8, 2'h0, 8'h0d);
    wt(7);
    chk("capture wrap count", 16'h00ff, cnt[15:8]);
    chk("interrupt", 16'h0001, irq[0]);
    ie = 3'h0;
    repeat (2) @(negedge clock_i);
    chk("masked interrupt", 16'h0000, irq[0]);
    ie = 3'h1;
    wr(8'hc8, 2'h0, 8'h09);
    rd(8'hc8, 2'h0, d);
    chk("written flag clear", 16'h0009, d);
    $display("test capture wrap done");
    rld = 16'hff00;
    @(negedge clock_i) rlw = 3'h1;
    @(negedge clock_i) rlw = 3'h0;
    wr(8'hc8, 2'h0, 8'h0c);
    wt(7);
    chk("underflow count", 16'h00ff, cnt[15:8]);
    dn = 3'h0;
    wr(8'hc8, 2'h0, 8'h04);
    wt(7);
    chk("reloaded count", 16'h00ff, cnt[15:8]);
    $display("test auto reload done");
    wr(8'hc8, 2'h0, 8'h08);
    tp = 3'h6;
    wt(6);
    chk("pin reload count", 16'hff00, cnt[15:0]);
    tp = 3'h7;
    wr(8'hc8, 2'h0, 8'h09);
    tp = 3'h6;
    wt(6);
    chk("captured count", 16'hff00, cap[15:0]);
    tp = 3'h7;
    $display("test pin events done");
    wr(8'hc8, 2'h0, 8'h06);
    repeat (4) @(negedge clock_i);
    chk("pin count idle", 16'hff00, cnt[15:0]);
    repeat (3)
    begin
      @(negedge clock_i) cp = 3'h6;
      repeat (4) @(negedge clock_i);
      cp = 3'h7;
      repeat (4) @(negedge clock_i);
    end
    repeat (6) @(negedge clock_i);
    chk("pin count", 16'hff03, cnt[15:0]);
    $display("test pin counting done");
    finish_test;
  end
endmodule // tb
